//--- mma_pkg.sv
/*
  Constants, region codes and carrier types for the processor memory
  addressing block. Assumes one synchronous clock domain.
*/
`default_nettype none
package mma_pkg;

  // ---------------------------------------------------------------
  // program space and vectors
  // ---------------------------------------------------------------
  localparam logic [15:0] MMA_RESET_VEC  = 16'h0000;
  localparam logic [15:0] MMA_VEC_BASE   = 16'h0003;
  localparam int          MMA_VEC_SHIFT  = 3;

  // ---------------------------------------------------------------
  // external data map
  // ---------------------------------------------------------------
  localparam logic [15:0] MMA_SHARED_HI  = 16'h13FF;
  localparam logic [15:0] MMA_CFG_LO     = 16'h2000;
  localparam logic [15:0] MMA_CFG_HI     = 16'h27FF;
  localparam logic [15:0] MMA_BATT_LO    = 16'h2800;
  localparam logic [15:0] MMA_BATT_HI    = 16'h287F;
  localparam int          MMA_SHARED_WORDS = 5120;
  localparam int          MMA_SHARED_AW  = 13;
  localparam logic [5:0]  MMA_ADC_PTR_RST = 6'h00;
  localparam logic [7:0]  MMA_UNMAPPED_RD = 8'h00;

  // ---------------------------------------------------------------
  // configuration fields snooped from writes
  // ---------------------------------------------------------------
  localparam logic [15:0] MMA_MUXDIV_ADDR = 16'h2100;
  localparam int          MMA_MUXDIV_LSB  = 4;
  localparam logic [3:0]  MMA_MUXDIV_RST  = 4'h0;
  localparam logic [15:0] MMA_CPUDIV_ADDR = 16'h2200;
  localparam logic [2:0]  MMA_CPUDIV_RST  = 3'h0;
  localparam logic [2:0]  MMA_CPUDIV_SLOWEST = 3'h4;
  localparam int          MMA_DIVCNT_W    = 6;
  localparam int          MMA_DIVBIT_BASE = 1;

  // ---------------------------------------------------------------
  // special function registers
  // ---------------------------------------------------------------
  localparam logic [7:0]  MMA_SFR_DPL0 = 8'h82;
  localparam logic [7:0]  MMA_SFR_DPH0 = 8'h83;
  localparam logic [7:0]  MMA_SFR_DPL1 = 8'h84;
  localparam logic [7:0]  MMA_SFR_DPH1 = 8'h85;
  localparam logic [7:0]  MMA_SFR_PSEL = 8'h92;
  localparam logic [7:0]  MMA_SFR_PAGE = 8'hBF;
  localparam logic [7:0]  MMA_PSEL_RST = 8'h00;
  localparam logic [7:0]  MMA_PAGE_RST = 8'h00;
  localparam logic [15:0] MMA_ACTIVE_DATA_POINTER_RST = 16'h0000;

  typedef enum logic [1:0] {
    MMA_RGN_NONE,
    MMA_RGN_SHARED,
    MMA_RGN_CFG,
    MMA_RGN_BATT
  } mma_rgn_t;

  typedef struct packed {
    logic       wr;
    logic       use_active_data_pointer;
    logic [7:0] ri;
    logic [7:0] wdata;
  } mma_xreq_t;

  typedef struct packed {
    logic        sel;
    logic        batt;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mma_cfg_t;

endpackage
`default_nettype wire

//--- mma_shared_ram.sv
/*
  Shared data RAM: one read/write port for the processor, one write port
  for converter samples. Read data is registered. Assumes single clock.
*/
`default_nettype none
module mma_shared_ram (
  input  wire logic                            clk_sys,  // system clock
  input  wire logic                            a_en,     // port a access
  input  wire logic                            a_wr,     // port a write
  input  wire logic [mma_pkg::MMA_SHARED_AW-1:0] a_addr, // port a address
  input  wire logic [7:0]                      a_wdata,  // port a write data
  output var  logic [7:0]                      a_rdata,  // port a read data
  input  wire logic                            b_wr,     // converter write
  input  wire logic [mma_pkg::MMA_SHARED_AW-1:0] b_addr, // converter address
  input  wire logic [7:0]                      b_wdata   // converter data
);
  import mma_pkg::*;

  logic [7:0] mem [MMA_SHARED_WORDS];

  // converter write last: it wins an address collision
  always_ff @(posedge clk_sys)
  begin
    if (a_en && a_wr)
    begin
      mem[a_addr] <= a_wdata;
    end
    if (a_en && !a_wr)
    begin
      a_rdata <= mem[a_addr];
    end
    if (b_wr)
    begin
      mem[b_addr] <= b_wdata;
    end
  end

endmodule
`default_nettype wire

//--- mma_addr.sv
/*
  Processor memory addressing: clock divider, program counter with reset
  and vector entry, pointer and page registers, external data decode with
  shared RAM and configuration RAM ports, converter sample writes.
  Assumes the core, flash and configuration RAM all run on clk_sys.
*/
`default_nettype none
module mma_addr (
  input  wire logic               clk_sys,        // master clock
  input  wire logic               sys_rst,        // async reset, high
  output var  logic               cpu_clock,      // divided processor clock
  input  wire logic               fetch_req,      // instruction fetch
  input  wire logic               jump_req,       // load program counter
  input  wire logic [15:0]        jump_addr,      // jump target
  input  wire logic               irq_take,       // vector entry
  input  wire logic [2:0]         irq_index,      // vector number
  input  wire logic               movc_req,       // code-memory move
  input  wire logic [15:0]        movc_addr,      // code-memory address
  output var  logic               prog_rd,        // flash read strobe
  output var  logic [15:0]        prog_addr,      // flash address
  input  wire logic               sfr_wr,         // sfr write
  input  wire logic               sfr_rd,         // sfr read
  input  wire logic [7:0]         sfr_addr,       // sfr address
  input  wire logic [7:0]         sfr_wdata,      // sfr write data
  output var  logic [7:0]         sfr_rdata,      // sfr read data
  input  wire logic               active_data_pointer_inc,       // increment active pointer
  input  wire logic               xreq_valid,     // MOVX request
  input  wire mma_pkg::mma_xreq_t xreq,           // MOVX details
  output var  logic               xdone,          // MOVX complete
  output var  logic [7:0]         xrdata,         // MOVX read data
  output var  mma_pkg::mma_cfg_t  cfg_bus,        // config RAM access
  input  wire logic [7:0]         cfg_rdata,      // config RAM read data
  input  wire logic               adc_valid,      // converter sample
  input  wire logic [7:0]         adc_data        // converter byte
);
  import mma_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [MMA_DIVCNT_W-1:0] div_cnt_q, div_cnt_d;
  logic [2:0]              cpu_div_q, cpu_div_d;
  logic [3:0]              mux_div_q, mux_div_d;
  logic [15:0]             pc_q, pc_d, prog_addr_d, xaddr;
  logic [7:0]              page_q, page_d, psel_q, psel_d, sfr_rdata_d;
  logic [15:0]             dp0_q, dp0_d, dp1_q, dp1_d, dp_act;
  logic [5:0]              adc_ptr_q, adc_ptr_d;
  mma_rgn_t                rgn, p1_rgn_q;
  logic                    p1_val_q, p1_wr_q, xdone_d, cpu_clock_d, prog_rd_d, adc_wr;
  logic [7:0]              xrdata_d, ram_rdata;
  mma_cfg_t                cfg_d;
  int                      div_bit;

  // ---------------------------------------------------------------
  // address forming and decode
  // ---------------------------------------------------------------
  always_comb
  begin
    dp_act = psel_q[0] ? dp1_q : dp0_q;
    xaddr = xreq.use_active_data_pointer ? dp_act : {page_q, xreq.ri};
    if (xaddr <= MMA_SHARED_HI)
      rgn = MMA_RGN_SHARED;
    else if (xaddr >= MMA_CFG_LO && xaddr <= MMA_CFG_HI)
      rgn = MMA_RGN_CFG;
    else if (xaddr >= MMA_BATT_LO && xaddr <= MMA_BATT_HI)
      rgn = MMA_RGN_BATT;
    else
      rgn = MMA_RGN_NONE;
  end

  // converter writes only while mux divide nonzero
  assign adc_wr = adc_valid && (mux_div_q != MMA_MUXDIV_RST);

  mma_shared_ram i_mma_shared_ram (
    .clk_sys (clk_sys),
    .a_en    (xreq_valid && rgn == MMA_RGN_SHARED),
    .a_wr    (xreq.wr),
    .a_addr  (xaddr[MMA_SHARED_AW-1:0]),
    .a_wdata (xreq.wdata),
    .a_rdata (ram_rdata),
    .b_wr    (adc_wr),
    .b_addr  ({{(MMA_SHARED_AW-6){1'b0}}, adc_ptr_q}),
    .b_wdata (adc_data)
  );

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  always_comb
  begin
    div_cnt_d = div_cnt_q + 1'b1;
    div_bit = MMA_DIVBIT_BASE + int'(cpu_div_q);
    if (cpu_div_q >= MMA_CPUDIV_SLOWEST)
      div_bit = MMA_DIVBIT_BASE + int'(MMA_CPUDIV_SLOWEST);
    cpu_clock_d = div_cnt_d[div_bit];
    // program reads on fetch and code move
    pc_d        = pc_q;
    prog_rd_d   = 1'b0;
    prog_addr_d = prog_addr;
    if (irq_take)
      pc_d = MMA_VEC_BASE + (16'(irq_index) << MMA_VEC_SHIFT);
    else if (jump_req)
      pc_d = jump_addr;
    else if (fetch_req)
    begin
      pc_d        = pc_q + 16'h0001;
      prog_rd_d   = 1'b1;
      prog_addr_d = pc_q;
    end
    if (movc_req && !fetch_req)
    begin
      prog_rd_d   = 1'b1;
      prog_addr_d = movc_addr;
    end
    page_d = page_q;
    psel_d = psel_q;
    dp0_d  = dp0_q;
    dp1_d  = dp1_q;
    if (sfr_wr)
    begin
      unique case (sfr_addr)
        MMA_SFR_PAGE: page_d = sfr_wdata;
        MMA_SFR_PSEL: psel_d = sfr_wdata;
        MMA_SFR_DPL0: dp0_d[7:0] = sfr_wdata;
        MMA_SFR_DPH0: dp0_d[15:8] = sfr_wdata;
        MMA_SFR_DPL1: dp1_d[7:0] = sfr_wdata;
        MMA_SFR_DPH1: dp1_d[15:8] = sfr_wdata;
        default: ;
      endcase
    end
    if (active_data_pointer_inc)
    begin
      if (psel_q[0])
        dp1_d = dp1_q + 16'h0001;
      else
        dp0_d = dp0_q + 16'h0001;
    end
    sfr_rdata_d = sfr_rdata;
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        MMA_SFR_PAGE: sfr_rdata_d = page_q;
        MMA_SFR_PSEL: sfr_rdata_d = psel_q;
        MMA_SFR_DPL0: sfr_rdata_d = dp0_q[7:0];
        MMA_SFR_DPH0: sfr_rdata_d = dp0_q[15:8];
        MMA_SFR_DPL1: sfr_rdata_d = dp1_q[7:0];
        MMA_SFR_DPH1: sfr_rdata_d = dp1_q[15:8];
        default:      sfr_rdata_d = MMA_UNMAPPED_RD;
      endcase
    end
    cfg_d.sel   = xreq_valid && (rgn == MMA_RGN_CFG || rgn == MMA_RGN_BATT);
    cfg_d.batt  = rgn == MMA_RGN_BATT;
    cfg_d.wr    = xreq.wr;
    cfg_d.addr  = xaddr;
    cfg_d.wdata = xreq.wdata;
    cpu_div_d   = cpu_div_q;
    mux_div_d   = mux_div_q;
    if (xreq_valid && xreq.wr && xaddr == MMA_CPUDIV_ADDR)
      cpu_div_d = xreq.wdata[2:0];
    if (xreq_valid && xreq.wr && xaddr == MMA_MUXDIV_ADDR)
      mux_div_d = xreq.wdata[MMA_MUXDIV_LSB +: 4];
    xdone_d  = p1_val_q;
    xrdata_d = xrdata;
    if (p1_val_q && !p1_wr_q)
    begin
      unique case (p1_rgn_q)
        MMA_RGN_SHARED: xrdata_d = ram_rdata;
        MMA_RGN_CFG, MMA_RGN_BATT: xrdata_d = cfg_rdata;
        MMA_RGN_NONE:   xrdata_d = MMA_UNMAPPED_RD;
      endcase
    end
    // sample pointer in lowest 0x40 bytes
    adc_ptr_d = adc_wr ? adc_ptr_q + 6'h01 : adc_ptr_q;
    if (mux_div_q == MMA_MUXDIV_RST)
      adc_ptr_d = MMA_ADC_PTR_RST;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_cnt_q <= '0;
      cpu_clock <= 1'b0;
      cpu_div_q <= MMA_CPUDIV_RST;
      mux_div_q <= MMA_MUXDIV_RST;
      pc_q      <= MMA_RESET_VEC;
      prog_rd   <= 1'b0;
      prog_addr <= MMA_RESET_VEC;
      page_q    <= MMA_PAGE_RST;
      psel_q    <= MMA_PSEL_RST;
      dp0_q     <= MMA_ACTIVE_DATA_POINTER_RST;
      dp1_q     <= MMA_ACTIVE_DATA_POINTER_RST;
      sfr_rdata <= MMA_UNMAPPED_RD;
      p1_val_q  <= 1'b0;
      p1_wr_q   <= 1'b0;
      p1_rgn_q  <= MMA_RGN_NONE;
      xdone     <= 1'b0;
      xrdata    <= MMA_UNMAPPED_RD;
      cfg_bus   <= '0;
      adc_ptr_q <= MMA_ADC_PTR_RST;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
      cpu_clock <= cpu_clock_d;
      cpu_div_q <= cpu_div_d;
      mux_div_q <= mux_div_d;
      pc_q      <= pc_d;
      prog_rd   <= prog_rd_d;
      prog_addr <= prog_addr_d;
      page_q    <= page_d;
      psel_q    <= psel_d;
      dp0_q     <= dp0_d;
      dp1_q     <= dp1_d;
      sfr_rdata <= sfr_rdata_d;
      p1_val_q  <= xreq_valid;
      p1_wr_q   <= xreq.wr;
      p1_rgn_q  <= rgn;
      xdone     <= xdone_d;
      xrdata    <= xrdata_d;
      cfg_bus   <= cfg_d;
      adc_ptr_q <= adc_ptr_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_clk_fast_half: assert property (
    $rose(cpu_clock) && cpu_div_q == 3'h0 && $past(cpu_div_q) == 3'h0
    |=> cpu_clock ##1 (cpu_div_q != 3'h0 || !cpu_clock))
    else $error("cpu clock high phase wrong at fastest divide");
  a_fetch_addr: assert property (
    fetch_req && !irq_take && !jump_req |=> prog_rd && prog_addr == $past(pc_q))
    else $error("fetch address not the program counter");
  a_vector_entry: assert property (
    irq_take |=> pc_q == 16'h0003 + 16'($past(irq_index)) * 16'h0008)
    else $error("vector entry address wrong");
  a_paged_upper: assert property (
    xreq_valid && !xreq.use_active_data_pointer && rgn != MMA_RGN_SHARED && rgn != MMA_RGN_NONE
    |=> cfg_bus.sel && cfg_bus.addr == {$past(page_q), $past(xreq.ri)})
    else $error("paged address not page over Ri");
  a_pointer_addr: assert property (
    xreq_valid && xreq.use_active_data_pointer && rgn == MMA_RGN_CFG
    |=> cfg_bus.addr == ($past(psel_q[0]) ? $past(dp1_q) : $past(dp0_q)))
    else $error("pointer address not the selected pointer");
  a_select_keeps: assert property (
    sfr_wr && sfr_addr == MMA_SFR_PSEL && !active_data_pointer_inc |=> $stable(dp0_q) && $stable(dp1_q))
    else $error("pointer changed by select write");
  a_page_write: assert property (
    sfr_wr && sfr_addr == MMA_SFR_PAGE |=> page_q == $past(sfr_wdata))
    else $error("page register not written at BF");
  a_done_latency: assert property (
    xreq_valid && !xreq.wr && rgn == MMA_RGN_NONE |-> ##2 xdone && xrdata == 8'h00)
    else $error("unmapped read answer wrong");
  a_adc_stop: assert property (
    mux_div_q == 4'h0 |=> adc_ptr_q == 6'h00)
    else $error("converter pointer moves with divide zero");
  a_batt_decode: assert property (
    xreq_valid && xreq.use_active_data_pointer && dp_act == 16'h2880 |=> !cfg_bus.sel)
    else $error("address past battery area selected");
  c_irq: cover property (irq_take ##2 fetch_req);
  c_paged_read: cover property (xreq_valid && !xreq.use_active_data_pointer && !xreq.wr ##2 xdone);
  c_select_flip: cover property (sfr_wr && sfr_addr == MMA_SFR_PSEL ##2 active_data_pointer_inc);
  c_adc_wrap: cover property (adc_wr && adc_ptr_q == 6'h3F);

endmodule
`default_nettype wire

//--- mma_cfg_model.sv
/*
  Behavioural configuration RAM standing behind cfg_bus: hardware
  control area and battery area. Assumes cfg_bus from mma_addr on clk_sys.
*/
`default_nettype none
module mma_cfg_model (
  input  wire logic              clk_sys,    // system clock
  input  wire mma_pkg::mma_cfg_t cfg_bus,    // access from the block
  output var  logic [7:0]        cfg_rdata   // read data to the block
);
  timeunit 1ns;
  timeprecision 100ps;
  import mma_pkg::*;
  logic [7:0]  mem [0:2175];
  logic [7:0]  last_q;
  logic [11:0] idx;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // control and battery areas
  assign idx = cfg_bus.batt ? {5'h10, cfg_bus.addr[6:0]} : {1'b0, cfg_bus.addr[10:0]};
  always @(posedge clk_sys)
  begin
    if (cfg_bus.sel && cfg_bus.wr)
      mem[idx] <= cfg_bus.wdata;
    if (cfg_bus.sel)
      last_q <= mem[idx];
  end
  // unselected: inverse of the last read value shown
  assign cfg_rdata = cfg_bus.sel ? mem[idx] : ~last_q;
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  Self-checking bench for mma_addr: program addressing, registers,
  external data decode, converter writes, processor clock divide.
  Assumes mma_cfg_model as the configuration RAM.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import mma_pkg::*;
  logic clk_sys, sys_rst, cpu_clock, fetch_req, jump_req, irq_take, movc_req;
  logic prog_rd, sfr_wr, sfr_rd, active_data_pointer_inc, xreq_valid, xdone, adc_valid;
  logic [15:0] jump_addr, movc_addr, prog_addr;
  logic [2:0]  irq_index;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xrdata, cfg_rdata, adc_data, rd;
  mma_xreq_t   xreq;
  mma_cfg_t    cfg_bus, cs;
  int          n_fail, samples_checked, cycles;

  mma_addr i_mma_addr (.clk_sys(clk_sys), .sys_rst(sys_rst), .cpu_clock(cpu_clock),
    .fetch_req(fetch_req), .jump_req(jump_req), .jump_addr(jump_addr),
    .irq_take(irq_take), .irq_index(irq_index), .movc_req(movc_req),
    .movc_addr(movc_addr), .prog_rd(prog_rd), .prog_addr(prog_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .active_data_pointer_inc(active_data_pointer_inc), .xreq_valid(xreq_valid), .xreq(xreq), .xdone(xdone),
    .xrdata(xrdata), .cfg_bus(cfg_bus), .cfg_rdata(cfg_rdata), .adc_valid(adc_valid),
    .adc_data(adc_data));
  mma_cfg_model i_mma_cfg_model (.clk_sys(clk_sys), .cfg_bus(cfg_bus),
    .cfg_rdata(cfg_rdata));

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    tick();
    sfr_wr = 1'b1; sfr_addr = a; sfr_wdata = d;
    tick();
    sfr_wr = 1'b0;
  endtask
  task automatic sr(input logic [7:0] a, input logic [7:0] e);
    tick();
    sfr_rd = 1'b1; sfr_addr = a;
    tick();
    sfr_rd = 1'b0;
    chk(sfr_rdata, e);
  endtask
  task automatic mx(input logic w, input logic p, input logic [7:0] ri, input logic [7:0] d);
    tick();
    xreq_valid = 1'b1; xreq = '{wr: w, use_active_data_pointer: p, ri: ri, wdata: d};
    tick();
    xreq_valid = 1'b0;
    cs = cfg_bus;
    tick();
    chk(xdone, 1'b1);
    rd = xrdata;
  endtask
  task automatic dx(input logic w, input logic [15:0] a, input logic [7:0] d);
    sw(MMA_SFR_DPL0, a[7:0]);
    sw(MMA_SFR_DPH0, a[15:8]);
    mx(w, 1'b1, 8'h00, d);
  endtask
  task automatic pc_chk(input logic [15:0] e);
    tick();
    fetch_req = 1'b1;
    tick();
    fetch_req = 1'b0;
    chk({prog_rd, prog_addr}, {1'b1, e});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_program();
    pc_chk(16'h0000);
    pc_chk(16'h0001);
    for (int i = 0; i < 8; i++)
    begin
      tick();
      irq_take = 1'b1; irq_index = i[2:0];
      tick();
      irq_take = 1'b0;
      pc_chk(16'h0003 + 16'(8 * i));
    end
    tick();
    jump_req = 1'b1; jump_addr = 16'hFFFF;
    tick();
    jump_req = 1'b0;
    pc_chk(16'hFFFF);
    pc_chk(16'h0000);
    tick();
    movc_req = 1'b1; movc_addr = 16'h8001;
    tick();
    movc_req = 1'b0;
    chk({prog_rd, prog_addr}, 17'h18001);
    tick();
    fetch_req = 1'b1;
    movc_req = 1'b1;
    tick();
    fetch_req = 1'b0;
    movc_req = 1'b0;
    chk({prog_rd, prog_addr}, 17'h10001);
  endtask
  task automatic t_page();
    sr(MMA_SFR_PAGE, 8'h00);
    sw(MMA_SFR_PAGE, 8'h13);
    mx(1'b1, 1'b0, 8'hFF, 8'h77);
    mx(1'b0, 1'b0, 8'hFF, 8'h00);
    chk({cs.sel, rd}, 9'h077);
    sw(MMA_SFR_PAGE, 8'h14);
    mx(1'b1, 1'b0, 8'h00, 8'h99);
    mx(1'b0, 1'b0, 8'h00, 8'h00);
    chk({cs.sel, rd}, 9'h000);
    sw(MMA_SFR_PAGE, 8'h20);
    mx(1'b1, 1'b0, 8'h10, 8'hC3);
    chk({cs.sel, cs.batt, cs.wr, 1'b0, cs.addr}, 20'hA2010);
    mx(1'b0, 1'b0, 8'h10, 8'h00);
    chk(rd, 8'hC3);
    sw(MMA_SFR_PAGE, 8'h28);
    mx(1'b0, 1'b0, 8'h80, 8'h00);
    chk({cs.sel, rd}, 9'h000);
    sr(MMA_SFR_PAGE, 8'h28);
  endtask
  task automatic t_pointers();
    sw(MMA_SFR_DPL0, 8'h23);
    sw(MMA_SFR_DPH0, 8'h01);
    sw(MMA_SFR_DPL1, 8'h05);
    sw(MMA_SFR_DPH1, 8'h28);
    sw(MMA_SFR_PSEL, 8'h01);
    sr(MMA_SFR_PSEL, 8'h01);
    mx(1'b1, 1'b1, 8'h00, 8'h3C);
    chk({cs.sel, cs.batt, cs.wr, 1'b0, cs.addr}, 20'hE2805);
    mx(1'b0, 1'b1, 8'h00, 8'h00);
    chk(rd, 8'h3C);
    sw(MMA_SFR_PSEL, 8'h00);
    tick();
    active_data_pointer_inc = 1'b1;
    tick();
    active_data_pointer_inc = 1'b0;
    sr(MMA_SFR_DPL0, 8'h24);
    sr(MMA_SFR_DPH0, 8'h01);
    sr(MMA_SFR_DPL1, 8'h05);
    sr(MMA_SFR_DPH1, 8'h28);
    sr(8'h90, 8'h00);
  endtask
  task automatic adc(input logic [7:0] d);
    tick();
    adc_valid = 1'b1; adc_data = d;
    tick();
    adc_valid = 1'b0;
  endtask
  task automatic t_adc();
    dx(1'b1, 16'h0000, 8'hA5);
    dx(1'b1, 16'h0040, 8'h5A);
    adc(8'h11);
    dx(1'b0, 16'h0000, 8'h00);
    chk(rd, 8'hA5);
    // mux divide written before any slot select
    sw(MMA_SFR_PAGE, 8'h21);
    mx(1'b1, 1'b0, 8'h00, 8'h70);
    for (int i = 0; i < 64; i++)
      adc(8'h80 + 8'(i));
    adc(8'hEE);
    dx(1'b0, 16'h0000, 8'h00);
    chk(rd, 8'hEE);
    dx(1'b0, 16'h003F, 8'h00);
    chk(rd, 8'hBF);
    dx(1'b0, 16'h0040, 8'h00);
    chk(rd, 8'h5A);
    sw(MMA_SFR_PAGE, 8'h21);
    mx(1'b1, 1'b0, 8'h00, 8'h00);
    adc(8'h44);
    dx(1'b0, 16'h0001, 8'h00);
    chk(rd, 8'h81);
    dx(1'b1, 16'h287F, 8'h6B);
    dx(1'b0, 16'h287F, 8'h00);
    chk({cs.sel, cs.batt, rd}, 10'h36B);
    dx(1'b0, 16'h2880, 8'h00);
    chk({cs.sel, rd}, 9'h000);
  endtask
  task automatic t_clock();
    int n;
    sw(MMA_SFR_PAGE, 8'h22);
    for (int c = 0; c < 8; c++)
    begin
      mx(1'b1, 1'b0, 8'h00, 8'(c));
      repeat (3)
      begin
        for (int k = 0; k < 150 && cpu_clock !== 1'b0; k++) tick();
        for (int k = 0; k < 150 && cpu_clock !== 1'b1; k++) tick();
      end
      n = 0;
      for (int k = 0; k < 150 && cpu_clock !== 1'b0; k++)
      begin
        tick();
        n++;
      end
      for (int k = 0; k < 150 && cpu_clock !== 1'b1; k++)
      begin
        tick();
        n++;
      end
      chk(n[19:0], 20'(4 << (c > 3 ? 4 : c)));
    end
  endtask
  task automatic t_reset();
    tick();
    sys_rst = 1'b1;
    tick();
    chk({cpu_clock, prog_rd, xdone, cfg_bus.sel}, 4'h0);
    tick();
    sys_rst = 1'b0;
    pc_chk(16'h0000);
    sr(MMA_SFR_PAGE, MMA_PAGE_RST);
  endtask

  // ---------------------------------------------------------------
  // clock, reset, sequence
  // ---------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      stop_test();
    end
  end
  initial
  begin
    n_fail = 0; samples_checked = 0; cycles = 0;
    sys_rst = 1'b1; fetch_req = 1'b0; jump_req = 1'b0; jump_addr = 16'h0000;
    irq_take = 1'b0; irq_index = 3'h0; movc_req = 1'b0; movc_addr = 16'h0000;
    sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
    active_data_pointer_inc = 1'b0; xreq_valid = 1'b0; xreq = '0; adc_valid = 1'b0; adc_data = 8'h00;
    repeat (3) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    t_program();
    t_page();
    t_pointers();
    t_adc();
    t_clock();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
